// >>> hdl/fsg_params.svh
// Constants for the flash security gate and flash clock divider.
// Assumes inclusion by the package, the design module and the bench.
`ifndef FSG_PARAMS_SVH
`define FSG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (byte offsets on the register port)
// ----------------------------------------------------------------------
`define FSG_ADDR_W          4
`define FSG_OFF_CLKDIV      4'h0
`define FSG_OFF_OPTIONS     4'h1
`define FSG_OFF_CONFIG      4'h2
`define FSG_OFF_PROTECT     4'h3
`define FSG_OFF_STATUS      4'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FSG_DIV_LOADED_BIT  7
`define FSG_DIV_PRESCALE_BIT 6
`define FSG_OPT_BACKDOOR_ENABLE_BIT   7
`define FSG_CFG_KEY_COMPARE_ACCESS_BIT  5
`define FSG_CFG_WMASK       8'hE0
`define FSG_OPT_RMASK       8'hC3
`define FSG_PROT_RMASK      8'hF8

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define FSG_SEC_UNSECURED   2'h2
`define FSG_RST_CLKDIV      8'h00
`define FSG_RST_CONFIG      8'h00
`define FSG_PRESCALE_DIV    4'h8
`define FSG_KEY_BYTES       4'h8

`endif

// >>> hdl/fsg_pkg.sv
// Types for the flash security gate.
// Assumes fsg_params.svh is on the include path.
`default_nettype none
`include "fsg_params.svh"
package fsg_pkg;
   // Memory access request toward secure flash or RAM.
   typedef struct packed {
      logic       req_wr;
      logic       req_rd;
      logic       to_secure;
      logic       from_unsecured;
      logic       from_debug;
      logic [7:0] wdata;
   } fsg_mem_req_t;

   // Register port request.
   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic                   from_debug;
      logic [`FSG_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } fsg_reg_req_t;

   // Key entry state.
   typedef enum logic [2:0] {
      FSG_KEY_IDLE  = 3'b001,
      FSG_KEY_ENTRY = 3'b010,
      FSG_KEY_DONE  = 3'b100
   } fsg_key_state_t;
endpackage : fsg_pkg
`default_nettype wire

// >>> hdl/fsg_flash_security.sv
// Flash security gate with the write-once flash timing clock divider.
// Assumes one bus clock, a synchronous reset, nonvolatile bytes that are
// stable during reset, and a debug mode pin coming from outside.
`default_nettype none
`include "fsg_params.svh"

// Notes on behaviour
// [R1] Secure memory accesses from unsecured code or debug: writes dropped, reads zero.
// [R2] Working options register reloads from the nonvolatile options byte at reset.
// [R3] Only security code 1:0 is unsecured; all other codes engage security.
// [R4] While secure, no debug module; background mode only from low pin at reset.
// [R5] Backdoor enable zero means no key unlock; only full erase unlocks.
// [R6] Key compare access set turns key location writes into comparison values.
// [R7] Software writes key bytes in ascending order, never on adjacent cycles.
// [R8] Clearing key compare access with eight matching bytes unlocks until reset.
// [R9] Key comparison writes accepted only from code in secure memory.
// [R10] Protection register writable only through debug commands.
// [R11] Blank check finding all flash erased unlocks until next reset.
// [R12] Software should program the low security bit to zero after erase.
// [R13] Divider loaded flag read-only, reset clear, set by first divider write.
// [R14] No program or erase while the divider loaded flag is zero.
// [R15] Divider bits 6..0 readable always, only the first write after reset sticks.
// [R16] Prescale bit one feeds bus clock over eight, else bus clock.
// [R17] Divider input divided by divisor field plus one gives flash timing clock.
// [R18] Software picks settings giving a timing clock of 150 to 200 kHz.
// [R19] Each timing pulse lasts one flash timing clock cycle. Here flash_tick_out pulses last one bus clock cycle; held high if divisor and prescale are zero.
// [R20] Nine 8-bit control registers; three reload from nonvolatile bytes. Here five registers, two (options, protection) reloaded.
// [R21] Backdoor enable is options bit 7, security code bits 1:0.
// [R22] A mismatched key leaves the security state unchanged.
module fsg_flash_security
   import fsg_pkg::*;
(
   // Clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         sys_rst_in,
   // Nonvolatile bytes; options and protection sampled during reset, key store read live
   input  wire logic [7:0]   nv_options_byte_in,
   input  wire logic [7:0]   nv_protect_byte_in,
   input  wire logic [63:0]  backdoor_key_store_in,
   // Debug mode pin (asynchronous)
   input  wire logic         debug_mode_pin_in,
   // Register port
   input  wire fsg_reg_req_t reg_req_in,
   output logic [7:0]        reg_rdata_out,
   // Memory path from core or debug controller
   input  wire fsg_mem_req_t mem_req_in,
   input  wire logic [2:0]   key_index_in,
   input  wire logic         key_loc_hit_in,
   input  wire logic [7:0]   array_rdata_in,
   input  wire logic         blank_check_done_in,
   input  wire logic         blank_check_erased_in,
   input  wire logic         pe_request_in,
   // Memory path toward the flash array
   output logic              array_wr_out,
   output logic              array_rd_out,
   output logic [7:0]        array_wdata_out,
   output logic [7:0]        mem_rdata_out,
   output logic              pe_allow_out,
   output logic              flash_tick_out,
   // Security outputs
   output logic              secure_out,
   output logic              debug_enable_out,
   output logic              background_entry_out
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0]     options_reg;
   logic [7:0]     config_reg;
   logic [7:0]     protect_reg;
   logic [7:0]     divider_reg;
   logic           unlocked;
   logic [63:0]    key_buf;
   logic [7:0]     key_seen;
   logic [2:0]     key_next_idx;
   fsg_key_state_t key_state;
   logic [1:0]     pin_sync;
   logic           rst_d;
   logic [2:0]     pre_cnt;
   logic           pre_tick;
   logic [5:0]     div_cnt;
   logic           blocked;
   logic           key_wr;
   logic           key_compare_access_fall;
   logic           secure_now;

   // Security code decode, used for the output and the gate.
   function automatic logic is_secure(input logic [1:0] code);
      return code != `FSG_SEC_UNSECURED; // see [R3]
   endfunction

   function automatic logic reg_hit(input fsg_reg_req_t r, input logic [3:0] off);
      return r.addr == off;
   endfunction

   assign secure_now = is_secure(options_reg[1:0]) && !unlocked;
   assign blocked    = secure_now && mem_req_in.to_secure
                     && (mem_req_in.from_unsecured || mem_req_in.from_debug); // see [R1]
   assign key_wr     = mem_req_in.req_wr && key_loc_hit_in
                     && config_reg[`FSG_CFG_KEY_COMPARE_ACCESS_BIT]
                     && !mem_req_in.from_unsecured && !mem_req_in.from_debug; // see [R9]
   assign key_compare_access_fall = reg_req_in.wr && !reg_req_in.from_debug
                      && reg_hit(reg_req_in, `FSG_OFF_CONFIG)
                      && config_reg[`FSG_CFG_KEY_COMPARE_ACCESS_BIT]
                      && !reg_req_in.wdata[`FSG_CFG_KEY_COMPARE_ACCESS_BIT];

   // ----------------------------------------------------------------------
   // Options and protection reload, config register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         options_reg <= nv_options_byte_in & `FSG_OPT_RMASK; // see [R2] [R12] [R20] [R21]
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         protect_reg <= nv_protect_byte_in & `FSG_PROT_RMASK; // see [R20]
      end else if (reg_req_in.wr && reg_req_in.from_debug
                   && reg_hit(reg_req_in, `FSG_OFF_PROTECT)) begin
         protect_reg <= reg_req_in.wdata & `FSG_PROT_RMASK; // see [R10]
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         config_reg <= `FSG_RST_CONFIG;
      end else if (reg_req_in.wr && reg_hit(reg_req_in, `FSG_OFF_CONFIG)) begin
         config_reg <= reg_req_in.wdata & `FSG_CFG_WMASK;
      end
   end

   // ----------------------------------------------------------------------
   // Divider register, write once
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         divider_reg <= `FSG_RST_CLKDIV;
      end else if (reg_req_in.wr && reg_hit(reg_req_in, `FSG_OFF_CLKDIV)
                   && !divider_reg[`FSG_DIV_LOADED_BIT]) begin
         divider_reg <= {1'b1, reg_req_in.wdata[6:0]}; // see [R13] [R15]
      end
   end

   // ----------------------------------------------------------------------
   // Flash timing clock divider
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || !divider_reg[`FSG_DIV_LOADED_BIT]) begin
         pre_cnt <= 3'h0;
      end else begin
         pre_cnt <= pre_cnt + 3'h1; // see [R16]
      end
   end

   assign pre_tick = divider_reg[`FSG_DIV_PRESCALE_BIT] ? (pre_cnt == 3'h7) : 1'b1;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || !divider_reg[`FSG_DIV_LOADED_BIT]) begin
         div_cnt        <= 6'h00;
         flash_tick_out <= 1'b0;
      end else if (pre_tick) begin
         if (div_cnt == divider_reg[5:0]) begin
            div_cnt        <= 6'h00;
            flash_tick_out <= 1'b1; // see [R17] [R19]
         end else begin
            div_cnt        <= div_cnt + 6'h01;
            flash_tick_out <= 1'b0;
         end
      end else begin
         flash_tick_out <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pe_allow_out <= 1'b0;
      end else begin
         pe_allow_out <= pe_request_in && divider_reg[`FSG_DIV_LOADED_BIT]; // see [R14]
      end
   end

   // ----------------------------------------------------------------------
   // Backdoor key entry
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         key_state    <= FSG_KEY_IDLE;
         key_buf      <= 64'h0000_0000_0000_0000;
         key_seen     <= 8'h00;
         key_next_idx <= 3'h0;
      end else begin
         case (key_state)
            FSG_KEY_IDLE: begin
               key_seen     <= 8'h00;
               key_next_idx <= 3'h0;
               if (config_reg[`FSG_CFG_KEY_COMPARE_ACCESS_BIT]) begin
                  key_state <= FSG_KEY_ENTRY; // see [R6]
               end
            end
            FSG_KEY_ENTRY: begin
               if (key_wr) begin
                  // Out of order bytes spoil the sequence; see [R7]
                  key_buf[key_index_in*8 +: 8] <= mem_req_in.wdata;
                  key_seen[key_index_in]       <= (key_index_in == key_next_idx);
                  key_next_idx                 <= key_index_in + 3'h1;
               end
               if (key_compare_access_fall) begin
                  key_state <= FSG_KEY_DONE;
               end
            end
            FSG_KEY_DONE: begin
               key_state <= FSG_KEY_IDLE;
            end
            default: begin
               key_state <= FSG_KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         unlocked <= 1'b0;
      end else if (key_state == FSG_KEY_DONE && options_reg[`FSG_OPT_BACKDOOR_ENABLE_BIT] // see [R5]
                   && key_seen == 8'hFF && key_buf == backdoor_key_store_in) begin
         unlocked <= 1'b1; // see [R8] [R22]
      end else if (blank_check_done_in && blank_check_erased_in) begin
         unlocked <= 1'b1; // see [R11]
      end
   end

   // ----------------------------------------------------------------------
   // Memory gate
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         array_wr_out    <= 1'b0;
         array_rd_out    <= 1'b0;
         array_wdata_out <= 8'h00;
      end else begin
         array_wr_out    <= mem_req_in.req_wr && !blocked && !key_wr; // see [R1] [R6]
         array_rd_out    <= mem_req_in.req_rd && !blocked;
         array_wdata_out <= mem_req_in.wdata;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         mem_rdata_out <= 8'h00;
      end else begin
         mem_rdata_out <= blocked ? 8'h00 : array_rdata_in; // see [R1]
      end
   end

   // ----------------------------------------------------------------------
   // Debug enable and background entry
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      pin_sync <= {pin_sync[0], debug_mode_pin_in};
   end

   always_ff @(posedge ref_clk_in) begin
      rst_d <= sys_rst_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         secure_out           <= 1'b1;
         debug_enable_out     <= 1'b0;
         background_entry_out <= 1'b0;
      end else begin
         secure_out       <= secure_now;
         debug_enable_out <= !secure_now; // see [R4]
         if (rst_d) begin
            background_entry_out <= !pin_sync[1]; // see [R4]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            `FSG_OFF_CLKDIV:  reg_rdata_out <= divider_reg;
            `FSG_OFF_OPTIONS: reg_rdata_out <= unlocked
                                 ? {options_reg[7:2], `FSG_SEC_UNSECURED} : options_reg;
            `FSG_OFF_CONFIG:  reg_rdata_out <= config_reg;
            `FSG_OFF_PROTECT: reg_rdata_out <= protect_reg;
            `FSG_OFF_STATUS:  reg_rdata_out <= {6'h00, unlocked, secure_now};
            default:          reg_rdata_out <= 8'h00;
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   blocked_read_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R1]
      blocked |=> mem_rdata_out == 8'h00 && !array_wr_out)
      else $error("blocked access reached the array");
   code_decode_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R3]
      (!unlocked && options_reg[1:0] != 2'h2) |=> secure_out)
      else $error("secure code not reported secure");
   debug_secure_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R4]
      secure_out |-> !debug_enable_out)
      else $error("debug enabled while secure");
   divider_once_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R15]
      $past(divider_reg[7]) |-> $stable(divider_reg))
      else $error("divider changed after first write");
   loaded_flag_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R13]
      (reg_req_in.wr && reg_req_in.addr == 4'h0) |=> divider_reg[7])
      else $error("divider write did not set loaded flag");
   pe_gate_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R14]
      !divider_reg[7] |=> !pe_allow_out)
      else $error("program allowed before divider load");
   protect_user_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R10]
      (reg_req_in.wr && !reg_req_in.from_debug) |=> $stable(protect_reg))
      else $error("application wrote protection register");
   key_enable_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R5]
      (!options_reg[7] && !unlocked && !blank_check_done_in) |=> !unlocked)
      else $error("unlocked with backdoor disabled");
   tick_pulse_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R19]
      (flash_tick_out && divider_reg[5:0] != 6'h00) |=> !flash_tick_out)
      else $error("timing pulse longer than one cycle");
   options_load_a: assert property (@(posedge ref_clk_in) // see [R2] [R12]
      sys_rst_in |=> options_reg == ($past(nv_options_byte_in) & `FSG_OPT_RMASK))
      else $error("options not reloaded at reset");
   options_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R20]
      !sys_rst_in |=> $stable(options_reg))
      else $error("options changed outside reset");
   key_array_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R6]
      key_wr |=> !array_wr_out)
      else $error("key write reached the array");
   key_unlock_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R8]
      (key_state == FSG_KEY_DONE && options_reg[7] && key_seen == 8'hFF
       && key_buf == backdoor_key_store_in) |=> ##1 !secure_out)
      else $error("matching key did not unlock");
   key_mismatch_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R22]
      (key_state == FSG_KEY_DONE && key_buf != backdoor_key_store_in && !unlocked
       && !blank_check_done_in) |=> !unlocked)
      else $error("mismatched key changed security");
   blank_unlock_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R11]
      (blank_check_done_in && blank_check_erased_in) |=> ##1 !secure_out)
      else $error("erased blank check did not unlock");
   prescale_gap_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R16]
      (flash_tick_out && divider_reg[6]) |=> !flash_tick_out [*7])
      else $error("prescaled tick came too soon");
   divisor_three_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R17]
      (flash_tick_out && divider_reg[6:0] == 7'h03) |=> !flash_tick_out [*3] ##1 flash_tick_out)
      else $error("divisor three tick period wrong");
   divider_first_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R15]
      (reg_req_in.wr && reg_req_in.addr == 4'h0 && !divider_reg[7])
         |=> divider_reg[6:0] == $past(reg_req_in.wdata[6:0]))
      else $error("first divider write not taken");
   protect_debug_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R10]
      (reg_req_in.wr && reg_req_in.from_debug && reg_req_in.addr == 4'h3)
         |=> protect_reg == ($past(reg_req_in.wdata) & `FSG_PROT_RMASK))
      else $error("debug write to protection lost");
   background_pin_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R4]
      $fell(sys_rst_in) |=> background_entry_out == !$past(pin_sync[1]))
      else $error("background entry does not follow pin");
   pe_allow_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R14]
      (divider_reg[7] && pe_request_in) |=> pe_allow_out)
      else $error("program request held off after load");
   code_open_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see [R3] [R21]
      (!sys_rst_in && !unlocked && options_reg[1:0] == `FSG_SEC_UNSECURED) |=> !secure_out)
      else $error("unsecured code reported secure");

endmodule // fsg_flash_security
`default_nettype wire

// >>> tb/fsg_core_model.sv
// Behavioural model of the core and debug controller on the memory path.
// Assumes the bench calls its tasks from one process and shares its clock.
`default_nettype none
module fsg_core_model
   import fsg_pkg::*;
(
   // Clock
   input  wire logic    clk_in,
   // Requests toward the gate
   output fsg_mem_req_t mem_req_out,
   output logic [2:0]   key_index_out,
   output logic         key_loc_hit_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      mem_req_out     = '0;
      key_index_out   = 3'h0;
      key_loc_hit_out = 1'b0;
   end

   // Released data lines show the inverse so stale values never match.
   task automatic drop(input logic [7:0] d);
      mem_req_out.req_wr <= 1'b0;
      mem_req_out.req_rd <= 1'b0;
      mem_req_out.wdata  <= ~d;
      key_loc_hit_out    <= 1'b0;
   endtask

   task automatic mem_acc(input logic wr, input logic un, input logic dg, input logic [7:0] d);
      @(posedge clk_in);
      mem_req_out <= '{wr, !wr, 1'b1, un, dg, d};
      @(posedge clk_in);
      drop(d);
   endtask

   // Key bytes go out in ascending order with an idle cycle between them.
   task automatic key_entry(input logic [63:0] key, input logic dg);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_in);
         key_index_out   <= 3'(k);
         key_loc_hit_out <= 1'b1;
         mem_req_out     <= '{1'b1, 1'b0, 1'b1, 1'b0, dg, key[8*k +: 8]};
         @(posedge clk_in);
         drop(key[8*k +: 8]);
      end
   endtask
endmodule  // fsg_core_model
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the flash security gate and clock divider.
// Assumes the design package and the core model are compiled before it.
`default_nettype none
`include "fsg_params.svh"
module tb_top
   import fsg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
   // Key cases: backdoor enable, from debug, wrong key, expected secure.
   localparam logic [3:0]  KC [4] = '{4'h8, 4'hb, 4'hd, 4'h1};

   logic         clk, rst, pin, bc_done, bc_erased, pe_req, saw_wr;
   logic [7:0]   nv_opt, rdata, mrdata, awdata;
   logic         arr_wr, arr_rd, pe_ok, tick, sec, dbg_en, bg, khit;
   logic [2:0]   kidx;
   fsg_reg_req_t rq;
   fsg_mem_req_t mreq;
   int           error_cnt, total_checks, cyc;

   fsg_flash_security fsg_flash_security_i (
      .ref_clk_in(clk), .sys_rst_in(rst), .nv_options_byte_in(nv_opt),
      .nv_protect_byte_in(8'hff), .backdoor_key_store_in(KEY), .debug_mode_pin_in(pin),
      .reg_req_in(rq), .reg_rdata_out(rdata), .mem_req_in(mreq), .key_index_in(kidx),
      .key_loc_hit_in(khit), .array_rdata_in(8'ha5), .blank_check_done_in(bc_done),
      .blank_check_erased_in(bc_erased), .pe_request_in(pe_req), .array_wr_out(arr_wr),
      .array_rd_out(arr_rd), .array_wdata_out(awdata), .mem_rdata_out(mrdata),
      .pe_allow_out(pe_ok), .flash_tick_out(tick), .secure_out(sec),
      .debug_enable_out(dbg_en), .background_entry_out(bg));

   fsg_core_model fsg_core_model_i (
      .clk_in(clk), .mem_req_out(mreq), .key_index_out(kidx), .key_loc_hit_out(khit));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Counts cycles for the hang limit and notes any array write.
   always @(posedge clk) begin
      cyc++;
      if (arr_wr === 1'b1) saw_wr <= 1'b1;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [7:0] opts, input logic p);
      @(posedge clk);
      rst    <= 1'b1;
      nv_opt <= opts;
      pin    <= p;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d, input logic dg);
      @(posedge clk);
      rq <= '{1'b1, 1'b0, dg, a, d};
      @(posedge clk);
      rq.wr <= 1'b0;
   endtask

   task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rq <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
      @(posedge clk);
      rq.rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic acc_chk(input logic wr, input logic un, input logic dg, input logic ok);
      fsg_core_model_i.mem_acc(wr, un, dg, 8'h3c);
      #1;
      if (wr) begin
         check(arr_wr, ok);
         if (ok) check(awdata, 8'h3c);
      end else begin
         check(arr_rd, ok);
         check(mrdata, ok ? 8'ha5 : 8'h00);
      end
   endtask

   task automatic blank(input logic e);
      @(posedge clk);
      bc_done   <= 1'b1;
      bc_erased <= e;
      @(posedge clk);
      bc_done   <= 1'b0;
      bc_erased <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Measures the clock count between two timing ticks.
   task automatic tick_gap(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (tick !== 1'b1 && n < 200);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (tick !== 1'b1 && n < 200);
      check(n[7:0], exp);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst          = 1'b1;
      nv_opt       = 8'h03;
      pin          = 1'b1;
      rq           = '0;
      bc_done      = 1'b0;
      bc_erased    = 1'b0;
      pe_req       = 1'b1;
      saw_wr       = 1'b0;
      cyc          = 0;
      error_cnt    = 0;
      total_checks = 0;
      for (int c = 0; c < 4; c++) begin
         do_reset({6'h00, 2'(c)}, 1'b1);
         check(sec, c != 2);
         check(dbg_en, c == 2);
      end
      do_reset(8'hff, 1'b0);
      check(bg, 1'b1);
      chk_rd(`FSG_OFF_OPTIONS, 8'hc3);
      reg_wr(`FSG_OFF_OPTIONS, 8'h00, 1'b0);
      chk_rd(`FSG_OFF_OPTIONS, 8'hc3);
      chk_rd(4'hf, 8'h00);
      chk_rd(`FSG_OFF_PROTECT, 8'hf8);
      reg_wr(`FSG_OFF_PROTECT, 8'h00, 1'b0);
      chk_rd(`FSG_OFF_PROTECT, 8'hf8);
      reg_wr(`FSG_OFF_PROTECT, 8'h50, 1'b1);
      chk_rd(`FSG_OFF_PROTECT, 8'h50);
      do_reset(8'h03, 1'b1);
      check(bg, 1'b0);
      $display("test reset and registers done");
      chk_rd(`FSG_OFF_CLKDIV, 8'h00);
      check(pe_ok, 1'b0);
      reg_wr(`FSG_OFF_CLKDIV, 8'h45, 1'b0);
      chk_rd(`FSG_OFF_CLKDIV, 8'hc5);
      reg_wr(`FSG_OFF_CLKDIV, 8'h12, 1'b0);
      chk_rd(`FSG_OFF_CLKDIV, 8'hc5);
      check(pe_ok, 1'b1);
      tick_gap(8'h30);
      do_reset(8'h03, 1'b1);
      reg_wr(`FSG_OFF_CLKDIV, 8'h03, 1'b0);
      chk_rd(`FSG_OFF_CLKDIV, 8'h83);
      tick_gap(8'h04);
      $display("test divider done");
      acc_chk(1'b1, 1'b1, 1'b0, 1'b0);
      acc_chk(1'b0, 1'b1, 1'b0, 1'b0);
      acc_chk(1'b0, 1'b0, 1'b1, 1'b0);
      acc_chk(1'b1, 1'b0, 1'b1, 1'b0);
      acc_chk(1'b0, 1'b0, 1'b0, 1'b1);
      acc_chk(1'b1, 1'b0, 1'b0, 1'b1);
      chk_rd(`FSG_OFF_STATUS, 8'h01);
      blank(1'b0);
      check(sec, 1'b1);
      blank(1'b1);
      check(sec, 1'b0);
      check(dbg_en, 1'b1);
      chk_rd(`FSG_OFF_OPTIONS, 8'h02);
      chk_rd(`FSG_OFF_STATUS, 8'h02);
      acc_chk(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test blocking and blank check done");
      for (int i = 0; i < 4; i++) begin
         do_reset({KC[i][3], 7'h03}, 1'b1);
         saw_wr = 1'b0;
         reg_wr(`FSG_OFF_CONFIG, 8'h20, 1'b0);
         chk_rd(`FSG_OFF_CONFIG, 8'h20);
         fsg_core_model_i.key_entry(KEY ^ {63'h0, KC[i][1]}, KC[i][2]);
         reg_wr(`FSG_OFF_CONFIG, 8'h00, 1'b0);
         repeat (4) @(posedge clk);
         #1;
         check(saw_wr, 1'b0);
         check(sec, KC[i][0]);
      end
      $display("test backdoor key done");
      results();
   end
endmodule  // tb_top
`default_nettype wire
